// file: verification/spi_master_slave_core_assertions.sv
// Checker for the SPI engine: pin release, idle clock, select level and status flags.
// Assumes it sees only the engine's top ports; bound into every engine instance.
`timescale 1ns/1ps
module spi_master_slave_core_assertions (
  // Clock, reset and controls
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic master_mode_i,
  input wire logic sel_out_dir_i,
  input wire logic sel_active_high_i,
  input wire logic clk_pol_i,
  input wire logic tx_write_i,
  input wire logic tx_overrun_clr_i,
  input wire logic rx_overrun_clr_i,
  // Observed outputs
  input wire logic busy_o,
  input wire logic tx_overrun_o,
  input wire logic rx_overrun_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic master_out_pin_o,
  input wire logic master_out_pin_oe_o,
  input wire logic master_in_pin_oe_o,
  input wire logic chip_select_pin_o,
  input wire logic chip_select_pin_oe_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Disabled port lets every pin float
  a_disabled_release: assert property (
    (!enable_i) [*2] |-> !(serial_clock_pin_oe_o || master_out_pin_oe_o ||
    master_in_pin_oe_o || chip_select_pin_oe_o)) else $error("pin driven while disabled");
  // Idle master parks its clock at the polarity level
  a_idle_clock_level: assert property (
    (enable_i && master_mode_i && !busy_o) [*3] |-> serial_clock_pin_oe_o &&
    serial_clock_pin_o == clk_pol_i) else $error("master clock not at idle level");
  // Slave drives neither clock, master-out nor select
  a_slave_inputs: assert property (
    (enable_i && !master_mode_i) [*2] |-> !serial_clock_pin_oe_o &&
    !master_out_pin_oe_o && !chip_select_pin_oe_o) else $error("slave drives an input pin");
  // Master with select output drives the select pin
  a_select_output: assert property (
    (enable_i && master_mode_i && sel_out_dir_i) [*2] |-> chip_select_pin_oe_o)
    else $error("select pin not driven");
  // Select is at its asserted level whenever the clock is away from idle
  a_select_level: assert property (
    enable_i && master_mode_i && chip_select_pin_oe_o && serial_clock_pin_oe_o &&
    serial_clock_pin_o != clk_pol_i |-> chip_select_pin_o == sel_active_high_i)
    else $error("select not asserted during clocking");
  // Master-out holds still across the sampling edge
  a_mosi_at_sample: assert property (
    enable_i && master_mode_i && $rose(serial_clock_pin_o ^ clk_pol_i) |->
    $stable(master_out_pin_o)) else $error("master-out moved at sampling edge");
  // Clock halves last at least two system clocks
  a_half_period_min: assert property (
    enable_i && master_mode_i && serial_clock_pin_oe_o && $changed(serial_clock_pin_o) |=>
    $stable(serial_clock_pin_o)) else $error("serial clock half period too short");
  // Overrun flags are sticky until cleared
  a_tx_overrun_hold: assert property (
    tx_overrun_o && !tx_overrun_clr_i |=> tx_overrun_o) else $error("transmit overrun lost");
  a_tx_overrun_clear: assert property (
    tx_overrun_o && tx_overrun_clr_i && !tx_write_i |=> !tx_overrun_o)
    else $error("transmit overrun not cleared");
  a_rx_overrun_hold: assert property (
    rx_overrun_o && !rx_overrun_clr_i |=> rx_overrun_o) else $error("receive overrun lost");
endmodule // spi_master_slave_core_assertions
bind spi_master_slave_core spi_master_slave_core_assertions i_chk (.sys_clk_i, .rst_i,
  .enable_i, .master_mode_i, .sel_out_dir_i, .sel_active_high_i, .clk_pol_i, .tx_write_i,
  .tx_overrun_clr_i, .rx_overrun_clr_i, .busy_o, .tx_overrun_o, .rx_overrun_o,
  .serial_clock_pin_o, .serial_clock_pin_oe_o, .master_out_pin_o, .master_out_pin_oe_o,
  .master_in_pin_oe_o, .chip_select_pin_o, .chip_select_pin_oe_o);

// file: verification/spi_master_slave_core_bench.sv
// Self-checking bench for the SPI engine: master role against a slave model,
// slave role against master strokes from the bench; pins resolve with pull-ups.
`timescale 1ns/1ps
module spi_master_slave_core_bench;
  import spi_core_pkg::*;
  // Design inputs
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i = 1'b0;
  logic master_mode_i = 1'b1;
  logic sel_out_dir_i = 1'b1;
  logic sel_active_high_i = 1'b0;
  logic clk_phase_i = 1'b0;
  logic clk_pol_i = 1'b0;
  logic [LEN_W-1:0] bit_count_i = 4'h8;
  logic [7:0] half_div_i = HALF_DIV_RST;
  logic tx_write_i = 1'b0;
  logic [CHAR_W-1:0] tx_data_i = 16'h0000;
  logic rx_read_i = 1'b0;
  logic tx_overrun_clr_i = 1'b0;
  logic rx_overrun_clr_i = 1'b0;
  // Design outputs
  logic [CHAR_W-1:0] rx_data_o;
  logic rx_valid_o, tx_overrun_o, rx_overrun_o, busy_o;
  logic serial_clock_pin_o, serial_clock_pin_oe_o, master_out_pin_o, master_out_pin_oe_o;
  logic master_in_pin_o, master_in_pin_oe_o, chip_select_pin_o, chip_select_pin_oe_o;
  // Bench master strokes, slave model and pulled-up wires
  logic m_drv = 1'b0, m_sck = 1'b0, m_mosi = 1'b1, m_cs = 1'b1;
  logic p_miso, p_oe;
  logic [15:0] p_got;
  wire sck_w = serial_clock_pin_oe_o ? serial_clock_pin_o : (m_drv ? m_sck : 1'b1);
  wire mosi_w = master_out_pin_oe_o ? master_out_pin_o : (m_drv ? m_mosi : 1'b1);
  wire miso_w = master_in_pin_oe_o ? master_in_pin_o : (p_oe ? p_miso : 1'b1);
  wire cs_w = chip_select_pin_oe_o ? chip_select_pin_o : (m_drv ? m_cs : 1'b1);
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  spi_master_slave_core i_dut (.sys_clk_i, .rst_i, .enable_i, .master_mode_i, .sel_out_dir_i,
    .sel_active_high_i, .clk_phase_i, .clk_pol_i, .bit_count_i, .half_div_i, .tx_write_i,
    .tx_data_i, .rx_read_i, .rx_data_o, .rx_valid_o, .tx_overrun_o, .tx_overrun_clr_i,
    .rx_overrun_o, .rx_overrun_clr_i, .busy_o, .serial_clock_pin_i(sck_w), .serial_clock_pin_o,
    .serial_clock_pin_oe_o, .master_out_pin_i(mosi_w), .master_out_pin_o, .master_out_pin_oe_o,
    .master_in_pin_i(miso_w), .master_in_pin_o, .master_in_pin_oe_o, .chip_select_pin_i(cs_w),
    .chip_select_pin_o, .chip_select_pin_oe_o);
  spi_slave_model i_slave (.sck_i(sck_w), .sel_n_i(cs_w ^ sel_active_high_i), .mosi_i(mosi_w),
    .pol_i(clk_pol_i), .active_i(!m_drv), .load_i(16'h3c96), .miso_o(p_miso),
    .miso_oe_o(p_oe), .got_o(p_got));
  // System clock
  initial
    forever #5 sys_clk_i = ~sys_clk_i;
  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // One transmit write pulse
  task automatic wr(input logic [15:0] d);
    tick(1);
    tx_write_i = 1'b1;
    tx_data_i = d;
    tick(1);
    tx_write_i = 1'b0;
  endtask
  // Wait for a received character, take it and pop it
  task automatic rd(output logic [15:0] d);
    repeat (3000) if (rx_valid_o !== 1'b1) tick(1);
    chk(rx_valid_o, 1'b1);
    d = rx_data_o;
    rx_read_i = 1'b1;
    tick(1);
    rx_read_i = 1'b0;
    tick(2);
  endtask
  task automatic idle();
    tick(4);
    repeat (3000) if (busy_o !== 1'b0) tick(1);
    chk(busy_o, 1'b0);
  endtask
  // Disable, then reconfigure
  task automatic setup(input logic mm, input logic ph, input logic pol, input logic [3:0] bc);
    tick(1);
    enable_i = 1'b0;
    tick(2);
    master_mode_i = mm;
    sel_out_dir_i = mm;
    sel_active_high_i = pol;
    clk_phase_i = ph;
    clk_pol_i = pol;
    bit_count_i = bc;
    m_drv = !mm;
    m_sck = pol;
    tick(2);
  endtask
  // Bench as master: one 8-bit character at the link rate
  task automatic sxfer(input logic [7:0] d, output logic [7:0] r);
    m_cs = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--)
    begin
      if (!clk_phase_i) m_mosi = d[i];
      #62.5;
      if (!clk_phase_i) r = {r[6:0], miso_w};
      m_sck = ~clk_pol_i;
      if (clk_phase_i) m_mosi = d[i];
      #62.5;
      if (clk_phase_i) r = {r[6:0], miso_w};
      m_sck = clk_pol_i;
    end
    #62.5;
    m_cs = 1'b1;
    m_mosi = ~m_mosi;
    tick(4);
  endtask
  initial
  begin
    logic [15:0] d;
    logic [7:0] r;
    tick(16);
    rst_i = 1'b0;
    tick(1);
    chk({serial_clock_pin_oe_o, master_out_pin_oe_o, master_in_pin_oe_o,
      chip_select_pin_oe_o}, 16'h0000);
    chk({chip_select_pin_o, tx_overrun_o, rx_overrun_o, rx_valid_o}, 16'h0008);
    // Master, 8-bit characters, both polarities and select levels
    for (int p = 0; p < 2; p++)
    begin
      setup(1'b1, 1'b0, p[0], 4'h8);
      enable_i = 1'b1;
      tick(4);
      chk(serial_clock_pin_o, p[0]);
      chk(chip_select_pin_o, !p[0]);
      wr(16'ha500);
      idle();
      chk(p_got[7:0], 8'ha5);
      rd(d);
      chk(d & 16'h00ff, 16'h003c);
    end
    // Full-width code, shortest divider, two characters queued while disabled
    setup(1'b1, 1'b0, 1'b0, LEN_FULL_CODE);
    half_div_i = HALF_DIV_MIN;
    wr(16'h1234);
    wr(16'hfedc);
    enable_i = 1'b1;
    idle();
    chk(p_got, 16'hfedc);
    rd(d);
    chk(d, 16'h3c96);
    rd(d);
    chk(d, 16'h1234);
    // Nine writes into eight places, then nine characters into eight places
    setup(1'b1, 1'b0, 1'b0, 4'h4);
    half_div_i = HALF_DIV_RST;
    for (int k = 0; k < 9; k++)
      wr({k[3:0], 12'h000});
    tick(2);
    chk(tx_overrun_o, 1'b1);
    tx_overrun_clr_i = 1'b1;
    tick(1);
    tx_overrun_clr_i = 1'b0;
    tick(1);
    chk(tx_overrun_o, 1'b0);
    enable_i = 1'b1;
    idle();
    wr(16'hf000);
    idle();
    chk(rx_overrun_o, 1'b1);
    rx_overrun_clr_i = 1'b1;
    tick(1);
    rx_overrun_clr_i = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rd(d);
      chk(d & 16'h000f, 16'((k < 4) ? (16'h3c96 >> (12 - 4 * k)) & 15 : k - 4));
    end
    chk({rx_valid_o, rx_overrun_o}, 16'h0000);
    // Slave in all four pairings, stray clocks while unselected first
    for (int m = 0; m < 4; m++)
    begin
      setup(1'b0, m[1], m[0], 4'h8);
      wr({8'hc3 ^ m[7:0], 8'h00});
      enable_i = 1'b1;
      tick(4);
      repeat (16) #62.5 m_sck = ~m_sck;
      sxfer(8'h5a ^ m[7:0], r);
      chk(r, 8'hc3 ^ m[7:0]);
      rd(d);
      chk(d & 16'h00ff, 16'h005a ^ 16'(m));
    end
    setup(1'b0, 1'b0, 1'b0, 4'h8);
    chk({serial_clock_pin_oe_o, master_in_pin_oe_o}, 16'h0000);
    wrap_up();
  end
endmodule // spi_master_slave_core_bench

// file: verification/spi_slave_model.sv
// Behavioural external SPI slave: 16-bit ring register, reloaded on select.
// Assumes phase-0 timing on the master side and a pulled-up line when released.
`timescale 1ns/1ps
module spi_slave_model (
  // Bus side
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  // Setup
  input wire logic pol_i,
  input wire logic active_i,
  input wire logic [15:0] load_i,
  // Outputs
  output logic miso_o,
  output logic miso_oe_o,
  output logic [15:0] got_o
);
  logic [15:0] shift_reg; // Ring half held by the slave
  logic in_bit; // Bit captured on the sampling edge
  wire sk = sck_i ^ pol_i; // Same polarity as the master
  // Drive only while selected
  assign miso_oe_o = active_i && !sel_n_i;
  assign miso_o = shift_reg[15];
  // Select loads a fresh character
  always @(negedge sel_n_i)
    if (active_i)
      shift_reg = load_i;
  // Sample on the leading edge
  always @(posedge sk)
    if (!sel_n_i)
    begin
      in_bit = mosi_i;
      got_o = {got_o[14:0], mosi_i};
    end
  // Shift the ring on the trailing edge
  always @(negedge sk)
    if (!sel_n_i)
      shift_reg = {shift_reg[14:0], in_bit};
endmodule // spi_slave_model

// file: verilog/char_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset and flush.
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage array
  logic [AW-1:0] wr_ptr_reg;  // Write pointer
  logic [AW-1:0] rd_ptr_reg;  // Read pointer
  logic [$clog2(DEPTH+1)-1:0] count_reg;  // Entries held
  logic push;
  logic pop;
  assign in_ready_o = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign level_o = count_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // Storage write
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end
  // Pointers and count
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // char_fifo

// file: verilog/spi_core_pkg.sv
// Constants for the dual-role SPI engine: widths, depths, reset values, timing.
// Assumes a 100 MHz system clock; consumers import the whole package.
package spi_core_pkg;
  // Character and FIFO shape
  localparam int CHAR_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LEN_W = 4;
  // Bit-count value zero selects a full-width character
  localparam logic [LEN_W-1:0] LEN_FULL_CODE = 4'h0;
  localparam logic [4:0] LEN_FULL = 5'h10;
  // Default bit-rate divider (half serial period in system clocks)
  localparam logic [7:0] HALF_DIV_RST = 8'h04;
  localparam logic [7:0] HALF_DIV_MIN = 8'h02;
  // Reset value of the select polarity control: active low
  localparam logic SEL_POL_RST = 1'b0;
  // Bit-phase states of the engine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b11,
    ST_DONE = 2'b10
  } engine_state_e;
endpackage

// file: verilog/spi_master_slave_core.sv
// Dual-role four-wire SPI engine with transmit and receive character FIFOs.
// Assumes pins are resolved outside from out/oe pairs; control bits are plain ports.
//
// Overview of operation
// - Disabled port releases all four pins.
// - Each character shifts out and in together.
// - Character length programmable from one to sixteen.
// - Sixteen-bit shift register, bit 15 first.
// - Separate eight-deep sixteen-bit transmit and receive FIFOs.
// - New transfer loads oldest transmit entry.
// - Completed character moves into receive FIFO.
// - Master drives serial clock from rate generator.
// - Slave ignores clock edges while unselected.
// - Data changes one edge, sampled opposite.
// - Phase and polarity pick slave transmit/receive edges; master ignores phase.
// - Polarity sets master idle clock level; with phase it also picks slave edges.
// - Both ends share phase and polarity settings.
// - Master presents data half cycle before latch.
// - Select asserted across each whole character.
// - Master with select output drives select pin.
// - Select polarity default active low; master only.
// - Mode zero means slave; direction zero, input.
// - Write to full transmit FIFO dropped, overrun.
// - Short received characters are right justified.
// - Bit count zero means sixteen bits.
`timescale 1ns/1ps
module spi_master_slave_core
  import spi_core_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic master_mode_i,
  input wire logic sel_out_dir_i,
  input wire logic sel_active_high_i,
  input wire logic clk_phase_i,
  input wire logic clk_pol_i,
  input wire logic [LEN_W-1:0] bit_count_i,
  input wire logic [7:0] half_div_i,
  // Transmit data write
  input wire logic tx_write_i,
  input wire logic [CHAR_W-1:0] tx_data_i,
  // Receive data read
  input wire logic rx_read_i,
  output logic [CHAR_W-1:0] rx_data_o,
  output logic rx_valid_o,
  // Status
  output logic tx_overrun_o,
  input wire logic tx_overrun_clr_i,
  output logic rx_overrun_o,
  input wire logic rx_overrun_clr_i,
  output logic busy_o,
  // Serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  // Master-out data pin
  input wire logic master_out_pin_i,
  output logic master_out_pin_o,
  output logic master_out_pin_oe_o,
  // Master-in data pin
  input wire logic master_in_pin_i,
  output logic master_in_pin_o,
  output logic master_in_pin_oe_o,
  // Chip select pin
  input wire logic chip_select_pin_i,
  output logic chip_select_pin_o,
  output logic chip_select_pin_oe_o
);
  initial
  begin
    if (DEPTH != FIFO_DEPTH) $error("FIFO depth must be eight");
  end

  // Length of a character in bits, zero code meaning full width
  function automatic logic [4:0] char_len(input logic [LEN_W-1:0] code);
    char_len = (code == LEN_FULL_CODE) ? LEN_FULL : {1'b0, code};
  endfunction

  // Pin synchronisers
  logic sck_s1_reg;  // First stage, read only by the second
  logic sck_s2_reg;
  logic sck_prev_reg;  // For edge detection
  logic sel_s1_reg;
  logic sel_s2_reg;
  logic mosi_s1_reg;
  logic mosi_s2_reg;
  logic miso_s1_reg;
  logic miso_s2_reg;

  // Engine state
  engine_state_e state_reg;
  logic [CHAR_W-1:0] shift_reg;  // Shared shift register
  logic [4:0] bits_left_reg;  // Bits still to shift
  logic [4:0] len_reg;  // Length latched at char start
  logic [7:0] div_cnt_reg;  // Rate generator counter
  logic sck_out_reg;  // Generated serial clock
  logic sel_act_reg;  // Master select active
  logic slave_armed_reg;  // Slave character in progress
  logic first_edge_reg;  // Slave: next edge is first of char

  // FIFO hookups
  logic tx_in_ready;
  logic tx_out_valid;
  logic [CHAR_W-1:0] tx_out_data;
  logic tx_pop;
  logic rx_push;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [CHAR_W-1:0] rx_out_data;
  logic [CHAR_W-1:0] rx_char;
  logic [$clog2(DEPTH+1)-1:0] tx_level;
  logic [$clog2(DEPTH+1)-1:0] rx_level;

  // Derived controls
  logic is_master;
  logic sel_in_act;
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;  // Edge where data is sampled in slave mode
  logic trail_edge;  // Opposite edge; unused, slave data moves after lead_edge
  logic din;
  logic [7:0] half_div;

  assign is_master = master_mode_i;
  assign sel_in_act = !sel_s2_reg;  // Slave select always active low at the slave
  assign sck_rise = sck_s2_reg && !sck_prev_reg;
  assign sck_fall = !sck_s2_reg && sck_prev_reg;
  // Receive edge: rising when phase equals polarity, else falling
  // Partner must use the same phase and polarity pairing
  assign lead_edge = (clk_phase_i == clk_pol_i) ? sck_rise : sck_fall;
  assign trail_edge = (clk_phase_i == clk_pol_i) ? sck_fall : sck_rise;
  assign din = is_master ? miso_s2_reg : mosi_s2_reg;
  assign half_div = (half_div_i < HALF_DIV_MIN) ? HALF_DIV_MIN : half_div_i;
  // Received bits right justified; the push edge is also the shift edge, so the
  // last bit is taken from the input directly into bit 0
  assign rx_char = {shift_reg[CHAR_W-2:0], din};

  // Transmit FIFO: writes beyond full are refused
  char_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(1'b0),
    .in_valid_i(tx_write_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_in_ready),
    .out_valid_o(tx_out_valid),
    .out_data_o(tx_out_data),
    .out_ready_i(tx_pop),
    .level_o(tx_level)
  );

  // Receive FIFO
  char_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(1'b0),
    .in_valid_i(rx_push),
    .in_data_i(rx_char),
    .in_ready_o(rx_in_ready),
    .out_valid_o(rx_out_valid),
    .out_data_o(rx_out_data),
    .out_ready_i(rx_read_i),
    .level_o(rx_level)
  );

  // Two-flop synchronisers for every pin input
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end
    else
    begin
      sck_s1_reg <= serial_clock_pin_i;
      sck_s2_reg <= sck_s1_reg;
      sck_prev_reg <= sck_s2_reg;
      sel_s1_reg <= chip_select_pin_i;
      sel_s2_reg <= sel_s1_reg;
      mosi_s1_reg <= master_out_pin_i;
      mosi_s2_reg <= mosi_s1_reg;
      miso_s1_reg <= master_in_pin_i;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // Transmit entry taken at the start of a character
  always_comb
  begin
    tx_pop = 1'b0;
    if (enable_i && tx_out_valid)
    begin
      if (is_master)
        tx_pop = (state_reg == ST_IDLE);
      else
        tx_pop = !slave_armed_reg && sel_in_act;
    end
  end

  // Character complete: push into receive FIFO if room
  always_comb
  begin
    rx_push = 1'b0;
    if (enable_i)
    begin
      // Master: last bit taken at the end of its trailing half
      if (is_master)
        rx_push = (state_reg == ST_TRAIL) && (div_cnt_reg == 8'h01) &&
          (bits_left_reg == 5'h00);
      else
        rx_push = (bits_left_reg == 5'h01) && slave_armed_reg && sel_in_act &&
          lead_edge;
    end
  end

  // Bit engine: master rate generator and clock, slave framing
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !enable_i)
    begin
      state_reg <= ST_IDLE;
      div_cnt_reg <= 8'h00;
      sck_out_reg <= 1'b0;
      sel_act_reg <= 1'b0;
      bits_left_reg <= 5'h00;
      len_reg <= LEN_FULL;
      slave_armed_reg <= 1'b0;
      first_edge_reg <= 1'b0;
    end
    else if (is_master)
    begin
      slave_armed_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          sck_out_reg <= 1'b0;
          if (tx_out_valid)
          begin
            sel_act_reg <= 1'b1;
            len_reg <= char_len(bit_count_i);
            bits_left_reg <= char_len(bit_count_i);
            div_cnt_reg <= half_div;
            state_reg <= ST_LEAD;
          end
          else
            sel_act_reg <= 1'b0;
        end
        ST_LEAD:
        begin
          // Half period with data set up, then the sampling edge
          if (div_cnt_reg == 8'h01)
          begin
            sck_out_reg <= 1'b1;
            div_cnt_reg <= half_div;
            bits_left_reg <= bits_left_reg - 5'h01;
            state_reg <= ST_TRAIL;
          end
          else
            div_cnt_reg <= div_cnt_reg - 8'h01;
        end
        ST_TRAIL:
        begin
          if (div_cnt_reg == 8'h01)
          begin
            sck_out_reg <= 1'b0;
            div_cnt_reg <= half_div;
            state_reg <= (bits_left_reg == 5'h00) ? ST_DONE : ST_LEAD;
          end
          else
            div_cnt_reg <= div_cnt_reg - 8'h01;
        end
        ST_DONE:
        begin
          // Select held through the character; next char reloads from FIFO
          state_reg <= ST_IDLE;
        end
      endcase
    end
    else
    begin
      // Slave: character framed by select, counted on receive edges
      state_reg <= ST_IDLE;
      sck_out_reg <= 1'b0;
      sel_act_reg <= 1'b0;
      if (!sel_in_act)
      begin
        slave_armed_reg <= 1'b0;
        first_edge_reg <= 1'b0;
      end
      else if (!slave_armed_reg)
      begin
        slave_armed_reg <= 1'b1;
        first_edge_reg <= 1'b1;
        len_reg <= char_len(bit_count_i);
        bits_left_reg <= char_len(bit_count_i);
      end
      else if (lead_edge)
      begin
        first_edge_reg <= 1'b0;
        if (bits_left_reg == 5'h01)
          slave_armed_reg <= 1'b0;
        else
          bits_left_reg <= bits_left_reg - 5'h01;
      end
    end
  end

  // Shift register: load on pop, shift MSB first. The master samples and shifts
  // at the end of the trailing half, so master-out only moves when the clock
  // returns to idle and the synchronised master-in has settled even at the
  // shortest divider.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      shift_reg <= '0;
    else if (tx_pop)
      shift_reg <= tx_out_data;
    else if (enable_i && is_master && state_reg == ST_TRAIL && div_cnt_reg == 8'h01)
      shift_reg <= {shift_reg[CHAR_W-2:0], din};
    else if (enable_i && !is_master && slave_armed_reg && sel_in_act && lead_edge)
      shift_reg <= {shift_reg[CHAR_W-2:0], din};
  end

  // Overrun flags: set wins over clear
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_overrun_o <= 1'b0;
      rx_overrun_o <= 1'b0;
    end
    else
    begin
      if (tx_write_i && !tx_in_ready)
        tx_overrun_o <= 1'b1;
      else if (tx_overrun_clr_i)
        tx_overrun_o <= 1'b0;
      if (rx_push && !rx_in_ready)
        rx_overrun_o <= 1'b1;
      else if (rx_overrun_clr_i)
        rx_overrun_o <= 1'b0;
    end
  end

  // Registered receive head and busy
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      rx_data_o <= rx_out_data;
      rx_valid_o <= rx_out_valid && !(rx_read_i && rx_level == 1);
      busy_o <= (state_reg != ST_IDLE) || slave_armed_reg || (tx_level != 0);
    end
  end

  // Pin drivers: all released while disabled
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !enable_i)
    begin
      serial_clock_pin_oe_o <= 1'b0;
      master_out_pin_oe_o <= 1'b0;
      master_in_pin_oe_o <= 1'b0;
      chip_select_pin_oe_o <= 1'b0;
      serial_clock_pin_o <= 1'b0;
      master_out_pin_o <= 1'b0;
      master_in_pin_o <= 1'b0;
      chip_select_pin_o <= 1'b1;
    end
    else
    begin
      // Polarity only inverts the clock
      serial_clock_pin_o <= sck_out_reg ^ clk_pol_i;
      serial_clock_pin_oe_o <= is_master;
      master_out_pin_oe_o <= is_master;
      master_in_pin_oe_o <= !is_master && sel_in_act;
      chip_select_pin_oe_o <= is_master && sel_out_dir_i;
      chip_select_pin_o <= is_master ? (sel_act_reg ~^ sel_active_high_i) : 1'b1;
      // Outgoing bit always the register MSB; it moves only when the register loads or shifts
      master_out_pin_o <= shift_reg[CHAR_W-1];
      master_in_pin_o <= shift_reg[CHAR_W-1];
    end
  end
endmodule // spi_master_slave_core
